// File: design/drv_cfg_pkg.sv
// Package: register map, field layout and bus codes of the driver
// and converter configuration bank.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
package drv_cfg_pkg;

    // Register indexes as printed; byte address is four times the index
    localparam int unsigned IDX_W          = 10;
    localparam logic [IDX_W-1:0] IDX_ALG_ONE = 10'h0A0;
    localparam logic [IDX_W-1:0] IDX_ALG_TWO = 10'h0A2;
    localparam logic [IDX_W-1:0] IDX_CFG     = 10'h0AE;

    // Values after reset
    localparam logic [31:0] CFG_RESET     = 32'h0120_0000;
    localparam logic [31:0] ALG_ONE_RESET = 32'h0000_0000;
    localparam logic [31:0] ALG_TWO_RESET = 32'h0000_0000;

    // Field positions of the configuration word
    localparam int unsigned BIT_PARITY     = 31;
    localparam int unsigned BIT_COMP_EN    = 30;
    localparam int unsigned BIT_DELAY_HI   = 29;
    localparam int unsigned BIT_DELAY_LO   = 26;
    localparam int unsigned BIT_SLEW       = 25;
    localparam int unsigned BIT_SEQ_OFF    = 24;
    localparam int unsigned BIT_CUR_CAP    = 23;
    localparam int unsigned BIT_VSEL_HI    = 22;
    localparam int unsigned BIT_VSEL_LO    = 21;
    localparam int unsigned BIT_CONV_OFF   = 20;
    localparam int unsigned SEQ_OFF_LANE   = 3;

    // Bus answer codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        REGION_NONE = 2'h0,
        REGION_CFG  = 2'h1,
        REGION_ALG  = 2'h3
    } region_t;

    typedef struct packed {
        logic       parity;
        logic       delay_comp_en;
        logic [3:0] target_delay;
        logic       converter_switch_slew;
        logic       converter_sequencing_off;
        logic       converter_current_cap;
        logic [1:0] converter_voltage_sel;
        logic       converter_off;
        logic [19:0] spare;
    } cfg_t;

endpackage

// File: design/alg_store.sv
// Small word store for the two internal algorithm locations.
// Assumes one clock; read data appear one cycle after rd_en.
`timescale 1ns/1ps
`default_nettype none
module alg_store
    import drv_cfg_pkg::*;
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 2
)(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [WIDTH/8-1:0]       wr_strb,
    input  wire logic                     rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output var  logic [WIDTH-1:0]         rd_data_reg
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Byte-lane write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= (i == 0) ? ALG_ONE_RESET : ALG_TWO_RESET;
            end
        end
        else if (wr_en)
        begin
            for (int b = 0; b < WIDTH/8; b++)
            begin
                if (wr_strb[b])
                begin
                    mem_reg[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
                end
            end
        end
    end

    // Registered read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_reg <= '0;
        end
        else if (rd_en)
        begin
            rd_data_reg <= mem_reg[rd_addr];
        end
    end

endmodule
`default_nettype wire

// File: design/drv_cfg_bank.sv
// Driver and converter configuration bank with an AXI4-Lite slave.
// Assumes a single clock and a master that follows AXI4-Lite handshakes.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - Configuration word at index AEh resets to 01200000h.
// R2 - Bit 30 enables driver delay compensation; resets to zero.
// R3 - Bits 29-26 pick target delay; zero means automatic from slew.
// R4 - Bit 25 picks converter switch slew rate; resets to zero.
// R5 - Bit 24 disables sequencing, resets to one, cleared by writing one.
// R6 - Bit 23 picks converter current limit; resets to zero.
// R7 - Bits 22-21 pick converter voltage; reset to one.
// R8 - Bit 20 turns converter off; bits 19-0 are plain storage.
// R9 - Software leaves algorithm locations A0h and A2h unchanged.
// R10 - Bit 31 is a plain stored parity bit, reset to zero.
module drv_cfg_bank
    import drv_cfg_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output var  cfg_t              drv_cfg
);

    function automatic region_t region_of(input logic [ADDR_W-1:0] a);
        logic [IDX_W-1:0] idx;
        idx = a[IDX_W+1:2];
        if (idx == IDX_CFG)
            return REGION_CFG;
        else if (idx == IDX_ALG_ONE || idx == IDX_ALG_TWO)
            return REGION_ALG;
        else
            return REGION_NONE;
    endfunction

    function automatic logic alg_slot(input logic [ADDR_W-1:0] a);
        return (a[IDX_W+1:2] == IDX_ALG_TWO);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction

    cfg_t              cfg_reg;
    cfg_t              cfg_next;
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              arready_reg;
    logic              rd_stage_reg;
    region_t           rd_region_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic [31:0]       alg_rd_data;
    logic              wr_fire;
    logic              ar_fire;
    region_t           wr_region;
    logic              cfg_we;
    logic              alg_we;

    assign wr_fire   = aw_full_reg && w_full_reg && !bvalid_reg;
    assign ar_fire   = s_axi_arvalid && arready_reg;
    assign wr_region = region_of(aw_addr_reg);
    assign cfg_we    = wr_fire && (wr_region == REGION_CFG);
    assign alg_we    = wr_fire && (wr_region == REGION_ALG);

    // Write address channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
        else if (bvalid_reg && s_axi_bready)
        begin
            aw_full_reg <= 1'b0;
        end
    end

    // Write data channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
        else if (bvalid_reg && s_axi_bready)
        begin
            w_full_reg <= 1'b0;
        end
    end

    // Ready flags mirror empty holding slots
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= (bvalid_reg && s_axi_bready) || (!aw_full_reg &&
                             !(s_axi_awvalid && s_axi_awready));
            s_axi_wready  <= (bvalid_reg && s_axi_bready) || (!w_full_reg &&
                             !(s_axi_wvalid && s_axi_wready));
        end
    end

    // Write response
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_region == REGION_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bvalid_reg && s_axi_bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // Next configuration word
    always_comb
    begin
        cfg_next = cfg_t'(merge(cfg_reg, w_data_reg, w_strb_reg)); // [R2] [R3] [R4] [R6] [R7] [R8] [R10]
        cfg_next.converter_sequencing_off = cfg_reg.converter_sequencing_off &
            ~(w_strb_reg[SEQ_OFF_LANE] & w_data_reg[BIT_SEQ_OFF]); // [R5]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_reg <= cfg_t'(CFG_RESET); // [R1]
        end
        else if (cfg_we)
        begin
            cfg_reg <= cfg_next;
        end
    end

    assign drv_cfg = cfg_reg;

    alg_store #(
        .WIDTH (32),
        .DEPTH (2)
    ) u_alg_store (
        .clk         (clk),
        .rst_n       (rst_n),
        .wr_en       (alg_we),
        .wr_addr     (alg_slot(aw_addr_reg)),
        .wr_data     (w_data_reg),
        .wr_strb     (w_strb_reg),
        .rd_en       (ar_fire),
        .rd_addr     (alg_slot(s_axi_araddr)),
        .rd_data_reg (alg_rd_data)
    );

    // Read address acceptance
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_reg   <= 1'b0;
            rd_stage_reg  <= 1'b0;
            rd_region_reg <= REGION_NONE;
        end
        else
        begin
            rd_stage_reg <= ar_fire;
            if (ar_fire)
            begin
                arready_reg   <= 1'b0;
                rd_region_reg <= region_of(s_axi_araddr);
            end
            else if (!rd_stage_reg && (!rvalid_reg || s_axi_rready))
            begin
                arready_reg <= 1'b1;
            end
        end
    end

    // Read data and response
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end
        else if (rd_stage_reg)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= (rd_region_reg == REGION_NONE) ? RESP_SLVERR
                                                         : RESP_OKAY;
            unique case (rd_region_reg)
                REGION_CFG: rdata_reg <= cfg_reg;
                REGION_ALG: rdata_reg <= alg_rd_data;
                default:    rdata_reg <= '0;
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // Checks
    logic after_rst_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            after_rst_reg <= 1'b0;
        else
            after_rst_reg <= 1'b1;
    end

    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence lane3_write;
        cfg_we && w_strb_reg[SEQ_OFF_LANE];
    endsequence

    chk_reset_word_value: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_n)
        !after_rst_reg |-> (cfg_reg == cfg_t'(CFG_RESET)))
        else $error("config word not at reset value");
    chk_comp_enable_store: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_n)
        lane3_write |=> cfg_reg.delay_comp_en == $past(w_data_reg[BIT_COMP_EN]))
        else $error("compensation enable not stored");
    chk_target_delay_store: assert property ( // [R3]
        @(posedge clk) disable iff (!rst_n)
        lane3_write |=> cfg_reg.target_delay ==
            $past(w_data_reg[BIT_DELAY_HI:BIT_DELAY_LO]))
        else $error("target delay not stored");
    chk_slew_select_store: assert property ( // [R4]
        @(posedge clk) disable iff (!rst_n)
        lane3_write |=> cfg_reg.converter_switch_slew ==
            $past(w_data_reg[BIT_SLEW]))
        else $error("slew select not stored");
    chk_sequencing_never_sets: assert property ( // [R5]
        @(posedge clk) disable iff (!rst_n)
        !$rose(cfg_reg.converter_sequencing_off))
        else $error("sequencing disable set after reset");
    chk_sequencing_w1c_clear: assert property ( // [R5]
        @(posedge clk) disable iff (!rst_n)
        cfg_we && w_strb_reg[SEQ_OFF_LANE] && w_data_reg[BIT_SEQ_OFF]
        |=> !cfg_reg.converter_sequencing_off)
        else $error("write one did not clear sequencing disable");
    chk_current_cap_store: assert property ( // [R6]
        @(posedge clk) disable iff (!rst_n)
        cfg_we && w_strb_reg[2] |=> cfg_reg.converter_current_cap ==
            $past(w_data_reg[BIT_CUR_CAP]))
        else $error("current limit not stored");
    chk_voltage_sel_store: assert property ( // [R7]
        @(posedge clk) disable iff (!rst_n)
        cfg_we && w_strb_reg[2] |=> cfg_reg.converter_voltage_sel ==
            $past(w_data_reg[BIT_VSEL_HI:BIT_VSEL_LO]))
        else $error("voltage select not stored");
    chk_converter_off_hold: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_n)
        !cfg_we |=> $stable(cfg_reg))
        else $error("config word changed without a write");
    chk_parity_bit_store: assert property ( // [R10]
        @(posedge clk) disable iff (!rst_n)
        lane3_write |=> cfg_reg.parity == $past(w_data_reg[BIT_PARITY]))
        else $error("parity bit not stored");
    chk_read_answer_time: assert property (
        @(posedge clk) disable iff (!rst_n)
        ar_taken |-> ##2 s_axi_rvalid)
        else $error("read answer not two cycles after address");

endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the driver and converter configuration bank.
// Assumes the bank answers every AXI4-Lite handshake within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import drv_cfg_pkg::*;

    localparam logic [11:0] A_CFG   = {IDX_CFG, 2'h0};
    localparam logic [11:0] A_ONE   = {IDX_ALG_ONE, 2'h0};
    localparam logic [11:0] A_TWO   = {IDX_ALG_TWO, 2'h0};
    localparam logic [11:0] A_BAD   = 12'h284;
    localparam logic [31:0] EXP_RST = 32'h0120_0000;

    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic [11:0] awaddr  = 12'h000;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready  = 1'b0;
    logic [11:0] araddr  = 12'h000;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready  = 1'b0;
    cfg_t        drv_cfg;
    logic [31:0] model   = 32'h0000_0000;
    logic [31:0] seed    = 32'hC629;
    int          mismatches = 0;
    int          cmp_count  = 0;

    always #10 clk = ~clk;

    drv_cfg_bank #(.ADDR_W(12)) u_drv_cfg_bank (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .drv_cfg(drv_cfg)
    );

    // Pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
    endfunction

    // Expected word after a write
    function automatic logic [31:0] cfg_after(input logic [31:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0]  s);
        logic [31:0] n;
        n = old;
        for (int b = 0; b < 4; b++)
            if (s[b])
                n[8*b +: 8] = d[8*b +: 8];
        n[24] = s[3] ? (old[24] & ~d[24]) : old[24];
        return n;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("MISMATCH at %0t: got %h, expected %h",
                     $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, resp});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input logic [1:0] resp);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready  <= 1'b0;
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, resp});
    endtask

    // Write the word, then compare outputs and read-back
    task automatic wr_cfg(input logic [31:0] d, input logic [3:0] s);
        model = cfg_after(model, d, s);
        wr(A_CFG, d, s, RESP_OKAY);
        check(drv_cfg, model);
        rd(A_CFG, model, RESP_OKAY);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        check(drv_cfg, EXP_RST);
        rst_n <= 1'b1;
        model = EXP_RST;
        @(posedge clk);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        logic [31:0] d;
        do_reset();
        rd(A_CFG, EXP_RST, RESP_OKAY);
        rd(A_ONE, 32'h0000_0000, RESP_OKAY);
        rd(A_TWO, 32'h0000_0000, RESP_OKAY);
        // Sequencing bit: zero keeps, lane off keeps, one clears
        wr_cfg(32'h0000_0000, 4'hF);
        wr_cfg(32'h0100_0000, 4'h7);
        wr_cfg(32'h0100_0000, 4'h8);
        wr_cfg(32'h0100_0000, 4'hF);
        // Every delay and voltage code with random other fields
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            d = seed;
            d[29:26] = i[3:0];
            d[22:21] = i[1:0];
            wr_cfg(d, 4'hF);
        end
        // Reset in mid-run restores the word
        do_reset();
        rd(A_CFG, EXP_RST, RESP_OKAY);
        // Random data under random byte strobes
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            d = seed;
            seed = lfsr(seed);
            wr_cfg(d, seed[7:4]);
        end
        // Unmapped place is refused and changes nothing
        wr(A_BAD, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        check(drv_cfg, model);
        rd(A_BAD, 32'h0000_0000, RESP_SLVERR);
        rd(A_ONE, 32'h0000_0000, RESP_OKAY);
        complete_run();
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
